// ### hdl/cbs_pkg.sv
// constants for the bias state controller
// assumes a 50 MHz system clock
package cbs_pkg;

  // clock
  localparam int CLK_MHZ = 50;

  // bus silence time in microseconds
  localparam int SILENCE_US = 1000;
  localparam int SILENCE_CYC = SILENCE_US * CLK_MHZ;

  // wake filter time in nanoseconds, least time
  localparam int WAKE_FILT_NS = 1000;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_W = 8;

  // bias states
  typedef enum logic [1:0] {
    CBS_OFF = 2'b00,
    CBS_AUTO_INACT = 2'b01,
    CBS_AUTO_ACT = 2'b10,
    CBS_ACTIVE = 2'b11
  } cbs_bias_t;

  // operating modes
  typedef enum logic [2:0] {
    CBS_NORMAL = 3'b000,
    CBS_SILENT = 3'b001,
    CBS_STANDBY = 3'b010,
    CBS_GOSLEEP = 3'b011,
    CBS_SLEEP = 3'b100
  } cbs_mode_t;

  // wake pattern detector stages
  typedef enum logic [1:0] {
    CBS_WK_DOM1 = 2'b00,
    CBS_WK_REC = 2'b01,
    CBS_WK_DOM2 = 2'b10
  } cbs_wake_t;

  // register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [2:0] CTRL_RST = 3'h2;

  // status field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_WAKE = 2;
  localparam int ST_BLOCK = 3;
  localparam int ST_SILENT = 4;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### hdl/cbs_bias_ctrl.sv
// bias state control of a CAN transceiver with AXI4-Lite registers
// assumes supply flags, bus level and txd are synchronous to sys_clk_i
//
// Contract
// - exactly one of off, auto inactive, auto active, active at a time
// - high voltage supply low enters off, bus left floating
// - high voltage supply ok moves off to auto inactive
// - standby, go-to-sleep and sleep use only autonomous biasing
// - auto inactive biases both bus pins to ground
// - remote wake moves auto inactive to auto active, bias at midpoint
// - auto active in low power falls to inactive when silence expires
// - entering low power picks active or inactive bias from bus idle time
// - normal or silent with a low supply enters auto active
// - active entered only on normal mode with both supplies ok
// - active state holds bias at half transceiver supply
// - normal runs driver and receiver; silent disables driver only
// - txd low before leaving standby blocks transmitter in active
// - active to auto inactive on low power after long silence
// - active to auto active on short silence or low supply
// - normal mode: txd low drives dominant, high releases recessive
// - normal and silent: rxd low for dominant, high otherwise
// - standby: rxd high, low only while wake pending
// - sleep modes: rxd high, tri-stated without io or hv supply
// - wake detection disabled in normal and silent
// - wake is filtered dominant, recessive, dominant, each filter time
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module cbs_bias_ctrl #(
  parameter int SILENCE_CYCLES = cbs_pkg::SILENCE_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // supply monitors
  input wire logic hv_supply_low_fall_i,
  input wire logic hv_supply_ok_rise_i,
  input wire logic xcvr_supply_low_fall_i,
  input wire logic xcvr_supply_ok_rise_i,
  input wire logic io_supply_low_fall_i,
  input wire logic io_supply_ok_rise_i,
  // controller side
  input wire logic txd_i,
  output logic rxd_o,
  output logic rxd_oe_o,
  // bus side
  input wire logic bus_dominant_i,
  output logic bus_drive_dom_o,
  output logic bias_gnd_o,
  output logic bias_mid_o,
  output logic bias_half_o,
  output logic rx_en_o,
  output logic wake_rx_en_o
);

  // software mode register
  logic [2:0] mode;
  logic [2:0] prev_mode;
  cbs_pkg::cbs_bias_t state;
  cbs_pkg::cbs_bias_t next_state;

  wire logic is_normal = (mode == cbs_pkg::CBS_NORMAL);
  wire logic is_silent = (mode == cbs_pkg::CBS_SILENT);
  wire logic is_standby = (mode == cbs_pkg::CBS_STANDBY);
  wire logic is_ns = is_normal | is_silent;
  wire logic is_lowpwr = ~is_ns;
  wire logic supply_low = xcvr_supply_low_fall_i | io_supply_low_fall_i;
  wire logic supply_ok = xcvr_supply_ok_rise_i & io_supply_ok_rise_i;
  wire logic left_standby = (prev_mode == cbs_pkg::CBS_STANDBY) & ~is_standby;

  // bus silence timer
  logic [31:0] idle_cnt;
  wire logic silence_exp = (idle_cnt >= SILENCE_CYCLES);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      idle_cnt <= '0;
    end else if (bus_dominant_i) begin
      idle_cnt <= '0;
    end else if (!silence_exp) begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end

  // wake pattern detector
  cbs_pkg::cbs_wake_t wk_stage;
  cbs_pkg::cbs_wake_t next_wk_stage;
  logic [cbs_pkg::FILT_W-1:0] filt_cnt;
  logic last_lvl;
  logic wake_pending;
  localparam logic [cbs_pkg::FILT_W-1:0] FILT_DONE =
    cbs_pkg::FILT_W'(cbs_pkg::WAKE_FILT_CYC);

  wire logic filt_ok = (filt_cnt >= FILT_DONE);
  wire logic wake_en = is_lowpwr;
  wire logic want_dom = (wk_stage != cbs_pkg::CBS_WK_REC);
  wire logic stage_hit = wake_en & filt_ok & (last_lvl == want_dom);
  wire logic wake_evt = stage_hit & (wk_stage == cbs_pkg::CBS_WK_DOM2);

  always_comb begin
    next_wk_stage = wk_stage;
    if (!wake_en) begin
      next_wk_stage = cbs_pkg::CBS_WK_DOM1;
    end else if (stage_hit) begin
      case (wk_stage)
        cbs_pkg::CBS_WK_DOM1: next_wk_stage = cbs_pkg::CBS_WK_REC;
        cbs_pkg::CBS_WK_REC: next_wk_stage = cbs_pkg::CBS_WK_DOM2;
        default: next_wk_stage = cbs_pkg::CBS_WK_DOM1;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      filt_cnt <= '0;
      last_lvl <= 1'b0;
      wk_stage <= cbs_pkg::CBS_WK_DOM1;
    end else begin
      last_lvl <= bus_dominant_i;
      wk_stage <= next_wk_stage;
      if (bus_dominant_i != last_lvl || stage_hit) begin
        filt_cnt <= '0;
      end else if (!filt_ok) begin
        filt_cnt <= filt_cnt + 1'b1;
      end
    end
  end

  // wake pending: set wins, cleared by normal mode
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wake_pending <= 1'b0;
    end else if (wake_evt) begin
      wake_pending <= 1'b1;
    end else if (is_normal) begin
      wake_pending <= 1'b0;
    end
  end

  // bias state machine
  always_comb begin
    next_state = state;
    case (state)
      cbs_pkg::CBS_OFF: begin
        if (hv_supply_ok_rise_i) begin
          next_state = cbs_pkg::CBS_AUTO_INACT;
        end
      end
      cbs_pkg::CBS_AUTO_INACT: begin
        if (is_normal & supply_ok & ~supply_low) begin
          next_state = cbs_pkg::CBS_ACTIVE;
        end else if (is_ns & supply_low) begin
          next_state = cbs_pkg::CBS_AUTO_ACT;
        end else if (wake_evt) begin
          next_state = cbs_pkg::CBS_AUTO_ACT;
        end
      end
      cbs_pkg::CBS_AUTO_ACT: begin
        if (is_normal & supply_ok & ~supply_low) begin
          next_state = cbs_pkg::CBS_ACTIVE;
        end else if (is_lowpwr & silence_exp) begin
          next_state = cbs_pkg::CBS_AUTO_INACT;
        end
      end
      cbs_pkg::CBS_ACTIVE: begin
        if (is_lowpwr) begin
          next_state = silence_exp ? cbs_pkg::CBS_AUTO_INACT
                                   : cbs_pkg::CBS_AUTO_ACT;
        end else if (supply_low) begin
          next_state = cbs_pkg::CBS_AUTO_ACT;
        end
      end
      default: next_state = cbs_pkg::CBS_OFF;
    endcase
    if (hv_supply_low_fall_i) begin
      next_state = cbs_pkg::CBS_OFF;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state <= cbs_pkg::CBS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // transmitter block against a stuck low txd
  logic tx_block;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_block <= 1'b0;
    end else if (left_standby & ~txd_i) begin
      tx_block <= 1'b1;
    end else if (state == cbs_pkg::CBS_ACTIVE && txd_i) begin
      tx_block <= 1'b0;
    end
  end

  // pin and bias outputs
  wire logic in_active = (state == cbs_pkg::CBS_ACTIVE);
  wire logic in_sleepy = is_lowpwr & ~is_standby;
  wire logic io_ok = io_supply_ok_rise_i & ~hv_supply_low_fall_i;

  logic next_drive;
  logic next_rxd;
  logic next_rxd_oe;

  always_comb begin
    next_drive = 1'b0;
    next_rxd = 1'b1;
    next_rxd_oe = 1'b1;
    if (is_normal) begin
      next_drive = in_active & ~tx_block & ~txd_i;
      next_rxd = ~bus_dominant_i;
    end else if (is_silent) begin
      next_rxd = ~bus_dominant_i;
    end else if (is_standby) begin
      next_rxd = ~wake_pending;
    end else begin
      next_rxd_oe = io_ok;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bus_drive_dom_o <= 1'b0;
      rxd_o <= 1'b1;
      rxd_oe_o <= 1'b0;
      bias_gnd_o <= 1'b0;
      bias_mid_o <= 1'b0;
      bias_half_o <= 1'b0;
      rx_en_o <= 1'b0;
      wake_rx_en_o <= 1'b0;
    end else begin
      bus_drive_dom_o <= next_drive;
      rxd_o <= next_rxd;
      rxd_oe_o <= next_rxd_oe;
      bias_gnd_o <= (next_state == cbs_pkg::CBS_AUTO_INACT);
      bias_mid_o <= (next_state == cbs_pkg::CBS_AUTO_ACT);
      bias_half_o <= (next_state == cbs_pkg::CBS_ACTIVE);
      rx_en_o <= is_ns;
      wake_rx_en_o <= in_sleepy | is_standby;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prev_mode <= cbs_pkg::CTRL_RST;
    end else begin
      prev_mode <= mode;
    end
  end

  // axi4-lite write path: address and data taken in either order
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
  assign s_axi_wready_o = ~w_held & ~s_axi_bvalid_o;

  wire logic aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire logic w_take = s_axi_wvalid_i & s_axi_wready_o;
  wire logic do_write = aw_held & w_held;
  wire logic wr_ctrl = (aw_addr == cbs_pkg::REG_CTRL);
  wire logic mode_legal = (w_data[2:0] <= cbs_pkg::CBS_SLEEP);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mode <= cbs_pkg::CTRL_RST;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= cbs_pkg::RESP_OKAY;
    end else begin
      if (do_write) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (wr_ctrl | (aw_addr == cbs_pkg::REG_STATUS))
                         ? cbs_pkg::RESP_OKAY : cbs_pkg::RESP_SLVERR;
        if (wr_ctrl & w_strb[0] & mode_legal) begin
          mode <= w_data[2:0];
        end
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // axi4-lite read path
  // status fields placed by the package positions
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[cbs_pkg::ST_STATE_LSB +: $bits(cbs_pkg::cbs_bias_t)] = state;
    status_word[cbs_pkg::ST_WAKE] = wake_pending;
    status_word[cbs_pkg::ST_BLOCK] = tx_block;
    status_word[cbs_pkg::ST_SILENT] = silence_exp;
  end

  assign s_axi_arready_o = ~s_axi_rvalid_o;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= cbs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i & s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= cbs_pkg::RESP_OKAY;
      if (s_axi_araddr_i == cbs_pkg::REG_CTRL) begin
        s_axi_rdata_o <= {29'h0, mode};
      end else if (s_axi_araddr_i == cbs_pkg::REG_STATUS) begin
        s_axi_rdata_o <= status_word;
      end else begin
        s_axi_rdata_o <= '0;
        s_axi_rresp_o <= cbs_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### bench/cbs_ctrl_model.sv
// protocol controller model on txd and rxd
// assumes a pull-up on the rxd line
`timescale 1ns/1ps
`default_nettype none
module cbs_ctrl_model (
  // clock
  input wire logic sys_clk_i,
  // bench command
  input wire logic send_dom_i,
  // transceiver side
  input wire logic rxd_i,
  input wire logic rxd_oe_i,
  output logic txd_o,
  output logic rx_seen_o
);
  always @(posedge sys_clk_i) begin
    txd_o <= !send_dom_i;
  end
  // released line reads high
  assign rx_seen_o = rxd_oe_i ? rxd_i : 1'b1;
endmodule
`default_nettype wire

// ### bench/cbs_bias_properties.sv
// port assertions for the bias controller
// assumes one clock, sync active high reset
`timescale 1ns/1ps
`default_nettype none
module cbs_bias_properties (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // supplies
  input wire logic hv_supply_low_fall_i,
  input wire logic hv_supply_ok_rise_i,
  input wire logic xcvr_supply_low_fall_i,
  input wire logic xcvr_supply_ok_rise_i,
  input wire logic io_supply_low_fall_i,
  input wire logic io_supply_ok_rise_i,
  // pins
  input wire logic txd_i,
  input wire logic bus_dominant_i,
  input wire logic rxd_o,
  input wire logic rxd_oe_o,
  input wire logic bus_drive_dom_o,
  input wire logic bias_gnd_o,
  input wire logic bias_mid_o,
  input wire logic bias_half_o,
  input wire logic rx_en_o,
  input wire logic wake_rx_en_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  wire logic [2:0] bias = {bias_gnd_o, bias_mid_o, bias_half_o};
  a_bias_onehot: assert property ($onehot0(bias))
    else $error("bias outputs not one-hot");
  a_hv_off: assert property (hv_supply_low_fall_i |=> bias == 3'h0)
    else $error("bias kept with hv supply low");
  a_off_rise: assert property (bias == 3'h0 && hv_supply_ok_rise_i && !hv_supply_low_fall_i |=> bias_gnd_o)
    else $error("off state not left on hv ok");
  a_half_entry: assert property ($rose(bias_half_o)
    |-> $past(xcvr_supply_ok_rise_i && io_supply_ok_rise_i))
    else $error("active bias without ok supplies");
  a_low_exit: assert property (xcvr_supply_low_fall_i || io_supply_low_fall_i |=> !bias_half_o)
    else $error("active bias kept with low supply");
  a_drive_gate: assert property (bus_drive_dom_o |-> !$past(txd_i) && rx_en_o)
    else $error("dominant drive without txd low");
  a_rx_follow: assert property (rx_en_o && $past(rx_en_o) |-> rxd_o == !$past(bus_dominant_i))
    else $error("rxd not following bus");
  a_wake_excl: assert property (rx_en_o |-> !wake_rx_en_o)
    else $error("wake receiver on with main receiver");
  a_rxd_float: assert property (!rxd_oe_o && !$past(srst_i) |-> wake_rx_en_o && !rx_en_o)
    else $error("rxd released outside sleep");
  c_wake: cover property ($rose(bias_mid_o));
  c_active: cover property ($rose(bias_half_o));
  c_drive: cover property (bus_drive_dom_o);
endmodule
bind cbs_bias_ctrl cbs_bias_properties chk_i (.sys_clk_i, .srst_i, .hv_supply_low_fall_i,
  .hv_supply_ok_rise_i, .xcvr_supply_low_fall_i, .xcvr_supply_ok_rise_i, .io_supply_low_fall_i,
  .io_supply_ok_rise_i, .txd_i, .bus_dominant_i, .rxd_o, .rxd_oe_o, .bus_drive_dom_o,
  .bias_gnd_o, .bias_mid_o, .bias_half_o, .rx_en_o, .wake_rx_en_o);
`default_nettype wire

// ### bench/tb_top.sv
// bench for the bias controller over axi4-lite
// assumes a 40 cycle silence time
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic hvl = 1'b1, hvo = 1'b0, xl = 1'b0, xo = 1'b1, il = 1'b0, io = 1'b1, bus = 1'b0, sd = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rxd, oe, drv, bg, bm, bh, rxen, wken, txd, rxs;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int n_mismatch = 0;
  int checked = 0;
  int cyc_n = 0;
  // drv rxd oe rxen wken gnd mid half
  wire logic [7:0] pv = {drv, rxd, oe, rxen, wken, bg, bm, bh};
  cbs_bias_ctrl #(.SILENCE_CYCLES(40)) uut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .hv_supply_low_fall_i(hvl), .hv_supply_ok_rise_i(hvo), .xcvr_supply_low_fall_i(xl),
    .xcvr_supply_ok_rise_i(xo), .io_supply_low_fall_i(il), .io_supply_ok_rise_i(io),
    .txd_i(txd), .rxd_o(rxd), .rxd_oe_o(oe), .bus_dominant_i(bus), .bus_drive_dom_o(drv),
    .bias_gnd_o(bg), .bias_mid_o(bm), .bias_half_o(bh), .rx_en_o(rxen), .wake_rx_en_o(wken));
  cbs_ctrl_model ctrl (.sys_clk_i(sys_clk_i), .send_dom_i(sd), .rxd_i(rxd), .rxd_oe_i(oe),
    .txd_o(txd), .rx_seen_o(rxs));
  always #10 sys_clk_i = ~sys_clk_i;
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge sys_clk_i);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge sys_clk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    logic ta, tr;
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge sys_clk_i);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge sys_clk_i);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask
  task automatic st(input logic [1:0] e);
    rd(4'h4);
    chk("state", 32'(d[1:0]), 32'(e));
  endtask
  task automatic pins(input logic [7:0] m, input logic [7:0] e);
    @(negedge sys_clk_i);
    chk("pins", 32'(pv & m), 32'(e));
    @(posedge sys_clk_i);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  initial begin
    wait_n(2);
    srst_i <= 1'b0;
    rd(4'h0);
    chk("mode", d, 32'h2);
    st(2'h0);
    pins(8'h87, 8'h00);
    hvl <= 1'b0;
    hvo <= 1'b1;
    wait_n(2);
    pins(8'h07, 8'h04);
    st(2'h1);
    $display("test power done");
    for (int i = 0; i < 3; i++) begin
      bus <= !bus;
      wait_n(60);
    end
    bus <= 1'b0;
    pins(8'h47, 8'h02);
    st(2'h2);
    chk("wake", 32'(d[2]), 32'h1);
    wait_n(50);
    st(2'h1);
    chk("silence", 32'(d[4]), 32'h1);
    $display("test wake done");
    wr(4'h0, 32'h0);
    st(2'h3);
    pins(8'h5F, 8'h51);
    sd <= 1'b1;
    bus <= 1'b1;
    wait_n(3);
    pins(8'hC0, 8'h80);
    wr(4'h0, 32'h1);
    wait_n(1);
    pins(8'h90, 8'h10);
    sd <= 1'b0;
    bus <= 1'b0;
    wr(4'h0, 32'h2);
    st(2'h2);
    pins(8'h07, 8'h02);
    wait_n(18);
    bus <= 1'b1;
    wait_n(1);
    bus <= 1'b0;
    wait_n(30);
    st(2'h2);
    wait_n(20);
    st(2'h1);
    wr(4'h0, 32'h0);
    wait_n(50);
    wr(4'h0, 32'h2);
    st(2'h1);
    $display("test silence done");
    sd <= 1'b1;
    wait_n(3);
    wr(4'h0, 32'h0);
    rd(4'h4);
    chk("block", 32'(d[3]), 32'h1);
    pins(8'h80, 8'h00);
    sd <= 1'b0;
    wait_n(3);
    sd <= 1'b1;
    wait_n(3);
    pins(8'h80, 8'h80);
    sd <= 1'b0;
    xl <= 1'b1;
    xo <= 1'b0;
    wait_n(2);
    st(2'h2);
    wr(4'h0, 32'h2);
    st(2'h1);
    wr(4'h0, 32'h1);
    st(2'h2);
    xl <= 1'b0;
    xo <= 1'b1;
    $display("test block done");
    wr(4'h0, 32'h4);
    pins(8'h78, 8'h68);
    io <= 1'b0;
    wait_n(2);
    chk("rx seen", 32'(rxs), 32'h1);
    pins(8'h20, 8'h00);
    io <= 1'b1;
    rd(4'h8);
    chk("rresp", 32'(r), 32'h2);
    wr(4'h8, 32'h0);
    chk("bresp", 32'(r), 32'h2);
    wr(4'h0, 32'h7);
    rd(4'h0);
    chk("mode", d, 32'h4);
    hvl <= 1'b1;
    hvo <= 1'b0;
    wait_n(2);
    st(2'h0);
    $display("test sleep done");
    wrap_up;
  end
endmodule
`default_nettype wire
